// [fsp_pkg.sv]
// constants and types shared by the flash self-programming sequencer
//
// Summary of operation
// RULE_01: store accepted only when enable fuse programmed zero
// RULE_02: software erases page before writing it
// RULE_03: buffer filled one word per store
// RULE_04: buffer words may load in any order
// RULE_05: code 00000011 plus store erases addressed page
// RULE_06: cpu halted for whole page erase
// RULE_07: code 00000001 plus store loads buffer word
// RULE_08: buffer cleared after write, clear bit, reset
// RULE_09: software loads each buffer word once only
// RULE_10: eeprom write during loading discards buffer
// RULE_11: code 00000101 plus store writes buffer to page
// RULE_12: cpu halted for whole page write
// RULE_13: z low bits word, high bits page
// RULE_14: software uses same page for erase, write
// RULE_15: load instruction picks byte by z bit zero
// RULE_16: software saves unchanged words before erasing
// RULE_17: enable lasts four cycles, held through operations
// RULE_18: unsupported control codes are ignored
// RULE_19: eeprom write blocks all flash programming
// RULE_20: page geometry set by parameters
// RULE_21: busy stalls cpu until flash operation completes
package fsp_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses on the bus)
  // ----------------------------------------------------------------
  localparam logic [7:0] FSP_CTRL_ADDR = 8'h00;  // program_memory_control_reg
  localparam logic [7:0] FSP_STAT_ADDR = 8'h04;  // status register

  // ----------------------------------------------------------------
  // control field layout and command codes
  // ----------------------------------------------------------------
  localparam int         FSP_CMD_W     = 5;      // low five control bits
  localparam int         FSP_EN_POS    = 0;      // self_program_enable
  localparam int         FSP_ERS_POS   = 1;      // page_erase_bit
  localparam int         FSP_WRT_POS   = 2;      // page_write_bit
  localparam int         FSP_CLR_POS   = 4;      // clear_page_buffer_bit
  localparam logic [4:0] FSP_CMD_LOAD  = 5'h01;
  localparam logic [4:0] FSP_CMD_ERASE = 5'h03;
  localparam logic [4:0] FSP_CMD_WRITE = 5'h05;
  localparam logic [4:0] FSP_CMD_CLEAR = 5'h11;
  localparam logic [4:0] FSP_CTRL_RST  = 5'h00;

  // ----------------------------------------------------------------
  // status bit positions
  // ----------------------------------------------------------------
  localparam int FSP_ST_BUSY  = 0;
  localparam int FSP_ST_FUSE  = 1;
  localparam int FSP_ST_EE    = 2;
  localparam int FSP_ST_DIRTY = 3;
  localparam int FSP_ST_ARMED = 4;

  // ----------------------------------------------------------------
  // timing and data values
  // ----------------------------------------------------------------
  localparam logic [2:0]  FSP_ARM_WINDOW = 3'h4;     // store window in cycles
  localparam logic [15:0] FSP_ERASED     = 16'hFFFF; // erased flash word

  // sequencer states
  typedef enum logic [2:0] {
    FSP_IDLE  = 3'b001,
    FSP_ARMED = 3'b010,
    FSP_BUSY  = 3'b100
  } fsp_state_e;

endpackage

// [fsp_core_if.sv]
// link between the sequencer control and the flash array core
`timescale 1ns/10ps
interface fsp_core_if #(
  parameter int WORD_BITS = 4,
  parameter int PAGE_BITS = 5
);
  logic                           load_stb;  // write one buffer word
  logic                           erase_stb; // start page erase
  logic                           write_stb; // start page write
  logic                           clear_stb; // drop buffer contents
  logic [WORD_BITS-1:0]           word_idx;  // word within page
  logic [PAGE_BITS-1:0]           page_idx;  // page number
  logic [15:0]                    wdata;     // data word for load
  logic [WORD_BITS+PAGE_BITS-1:0] rd_addr;   // word address for reads
  logic [15:0]                    rd_word;   // flash word at rd_addr
  logic                           done;      // operation finished pulse
  logic                           dirty;     // buffer holds loaded data

  modport ctrl (output load_stb, erase_stb, write_stb, clear_stb, word_idx,
                page_idx, wdata, rd_addr, input rd_word, done, dirty);
  modport core (input load_stb, erase_stb, write_stb, clear_stb, word_idx,
                page_idx, wdata, rd_addr, output rd_word, done, dirty);
endinterface

// [fsp_flash_core.sv]
// flash array, temporary page buffer and operation timer
`timescale 1ns/10ps
module fsp_flash_core
  import fsp_pkg::*;
#(
  parameter int WORD_BITS = 4,
  parameter int PAGE_BITS = 5,
  parameter int OP_CYCLES = 1000
) (
  input wire logic REF_CLK,
  input wire logic RST_B,
  fsp_core_if.core cif
);

  localparam int PAGE_WORDS = 1 << WORD_BITS;
  localparam int ALL_WORDS  = 1 << (WORD_BITS + PAGE_BITS);

  logic [15:0]          page_buf [PAGE_WORDS]; // temporary page buffer
  logic [15:0]          flash    [ALL_WORDS];  // program memory
  logic [31:0]          cnt_reg;               // operation timer
  logic                 run_reg;               // operation in flight
  logic                 ers_reg;               // 1 erase, 0 write
  logic [PAGE_BITS-1:0] page_reg;              // latched target page
  logic                 done_reg;
  logic                 dirty_reg;

  // ----------------------------------------------------------------
  // buffer: reset and clear fill it with erased words
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      for (int i = 0; i < PAGE_WORDS; i++) begin
        page_buf[i] <= FSP_ERASED;                        // [RULE_08]
      end
    end else if (cif.clear_stb || (done_reg && !ers_reg)) begin
      for (int i = 0; i < PAGE_WORDS; i++) begin
        page_buf[i] <= FSP_ERASED;                        // [RULE_08] [RULE_10]
      end
    end else if (cif.load_stb) begin
      page_buf[cif.word_idx] <= cif.wdata;                // [RULE_03] [RULE_04]
    end
  end

  // ----------------------------------------------------------------
  // timer and flags; memory is not reset, like real flash
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      cnt_reg   <= '0;
      run_reg   <= 1'b0;
      ers_reg   <= 1'b0;
      page_reg  <= '0;
      done_reg  <= 1'b0;
      dirty_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (cif.erase_stb || cif.write_stb) begin
        run_reg  <= 1'b1;
        ers_reg  <= cif.erase_stb;
        page_reg <= cif.page_idx;
        cnt_reg  <= '0;
      end else if (run_reg) begin
        if (cnt_reg == 32'(OP_CYCLES - 1)) begin
          run_reg  <= 1'b0;
          done_reg <= 1'b1;                               // [RULE_21]
        end else begin
          cnt_reg <= cnt_reg + 32'h1;
        end
      end
      // loading sets dirty; clear, reset or finished write drop it
      if (cif.load_stb) begin
        dirty_reg <= 1'b1;
      end else if (cif.clear_stb || (done_reg && !ers_reg)) begin
        dirty_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // array update at the end of the timed operation
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (run_reg && cnt_reg == 32'(OP_CYCLES - 1)) begin
      for (int i = 0; i < PAGE_WORDS; i++) begin
        // programming only pulls bits low, so erase must come first
        flash[{page_reg, WORD_BITS'(i)}] <= ers_reg ? FSP_ERASED
          : (flash[{page_reg, WORD_BITS'(i)}] & page_buf[i]); // [RULE_05] [RULE_11]
      end
    end
  end

  assign cif.rd_word = flash[cif.rd_addr];
  assign cif.done    = done_reg;
  assign cif.dirty   = dirty_reg;

endmodule // fsp_flash_core

// [fsp_seq.sv]
// self-programming sequencer top: bus slave, command arming, cpu stall
//
// Added by the designer: the Wishbone register port and the register offsets.
`timescale 1ns/10ps
module fsp_seq
  import fsp_pkg::*;
#(
  parameter int WORD_BITS = 4,     // word-in-page field width
  parameter int PAGE_BITS = 5,     // page field width
  parameter int OP_CYCLES = 1000   // erase/write duration in cycles
) (
  input  wire logic        REF_CLK,
  input  wire logic        RST_B,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  input  wire logic        STORE_STB,
  input  wire logic        LOAD_STB,
  input  wire logic [15:0] Z_ADDR,
  input  wire logic [15:0] STORE_DATA,
  input  wire logic        EE_WRITE_BUSY,
  input  wire logic        SELF_PROG_FUSE_B,
  output logic      [7:0]  LOAD_BYTE,
  output logic             LOAD_VALID,
  output logic             CPU_HALT
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  fsp_core_if #(.WORD_BITS(WORD_BITS), .PAGE_BITS(PAGE_BITS)) cif ();

  fsp_state_e          state_reg, state_next;  // sequencer state
  logic [FSP_CMD_W-1:0] ctrl_reg, ctrl_next;   // control bits
  logic [2:0]          win_reg, win_next;      // store window left
  logic                halt_reg, halt_next;    // cpu stall
  logic                ack_reg, ack_next;      // bus acknowledge
  logic [31:0]         dat_reg, dat_next;      // bus read data
  logic [7:0]          byte_reg, byte_next;    // load instruction byte
  logic                lval_reg, lval_next;    // load result valid
  logic                bus_req;                // new bus cycle
  logic                ctrl_wr;                // write to control reg
  logic                fuse_ok;                // store instruction enabled

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // only the listed combinations have an effect
  function automatic logic cmd_valid(input logic [FSP_CMD_W-1:0] c);
    return (c == FSP_CMD_LOAD) || (c == FSP_CMD_ERASE) ||
           (c == FSP_CMD_WRITE) || (c == FSP_CMD_CLEAR);   // [RULE_18]
  endfunction

  assign bus_req = WB_CYC_I && WB_STB_I && !ack_reg;
  assign ctrl_wr = bus_req && WB_WE_I && WB_SEL_I[0] && (WB_ADR_I == FSP_CTRL_ADDR);
  assign fuse_ok = !SELF_PROG_FUSE_B;                        // [RULE_01]

  // z pointer split: bit 0 byte, then word, then page
  assign cif.word_idx = Z_ADDR[WORD_BITS:1];                               // [RULE_13]
  assign cif.page_idx = Z_ADDR[WORD_BITS+PAGE_BITS:WORD_BITS+1];           // [RULE_13]
  assign cif.wdata    = STORE_DATA;
  assign cif.rd_addr  = Z_ADDR[WORD_BITS+PAGE_BITS:1];

  // ----------------------------------------------------------------
  // wishbone slave: one-cycle ack, zero for unmapped addresses
  // ----------------------------------------------------------------
  always_comb begin
    ack_next = bus_req;
    dat_next = dat_reg;
    if (bus_req && !WB_WE_I) begin
      case (WB_ADR_I)
        FSP_CTRL_ADDR: dat_next = {27'h0, ctrl_reg};
        FSP_STAT_ADDR: begin
          dat_next = 32'h0;
          dat_next[FSP_ST_BUSY]  = (state_reg == FSP_BUSY);
          dat_next[FSP_ST_FUSE]  = fuse_ok;
          dat_next[FSP_ST_EE]    = EE_WRITE_BUSY;
          dat_next[FSP_ST_DIRTY] = cif.dirty;
          dat_next[FSP_ST_ARMED] = (state_reg == FSP_ARMED);
        end
        default: dat_next = 32'h0;   // unmapped reads as zero
      endcase
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0;
    end else begin
      ack_reg <= ack_next;
      dat_reg <= dat_next;
    end
  end

  // ----------------------------------------------------------------
  // sequencer: arming, store window, timed operations
  // ----------------------------------------------------------------
  always_comb begin
    state_next    = state_reg;
    ctrl_next     = ctrl_reg;
    win_next      = win_reg;
    halt_next     = halt_reg;
    cif.load_stb  = 1'b0;
    cif.erase_stb = 1'b0;
    cif.write_stb = 1'b0;
    // an eeprom write in the middle of loading loses the buffer
    cif.clear_stb = EE_WRITE_BUSY && cif.dirty;               // [RULE_10]
    case (state_reg)
      FSP_IDLE: begin
        // eeprom activity or a blank fuse blocks all arming
        if (ctrl_wr && fuse_ok && !EE_WRITE_BUSY &&
            cmd_valid(WB_DAT_I[FSP_CMD_W-1:0])) begin         // [RULE_19] [RULE_18]
          if (WB_DAT_I[FSP_CLR_POS]) begin
            cif.clear_stb = 1'b1;                             // [RULE_08]
          end else begin
            ctrl_next  = WB_DAT_I[FSP_CMD_W-1:0];
            win_next   = FSP_ARM_WINDOW;                      // [RULE_17]
            state_next = FSP_ARMED;
          end
        end
      end
      FSP_ARMED: begin
        if (EE_WRITE_BUSY) begin
          // cancel: eeprom write started while armed
          ctrl_next  = FSP_CTRL_RST;                          // [RULE_19]
          state_next = FSP_IDLE;
        end else if (STORE_STB) begin
          if (ctrl_reg == FSP_CMD_LOAD) begin
            cif.load_stb = 1'b1;                              // [RULE_07] [RULE_03]
            ctrl_next    = FSP_CTRL_RST;
            state_next   = FSP_IDLE;
          end else begin
            // erase or write: data word ignored, enable stays up
            cif.erase_stb = ctrl_reg[FSP_ERS_POS];            // [RULE_05]
            cif.write_stb = ctrl_reg[FSP_WRT_POS];            // [RULE_11]
            halt_next     = 1'b1;                             // [RULE_06] [RULE_12]
            state_next    = FSP_BUSY;
          end
        end else if (win_reg == 3'h1) begin
          // window elapsed with no store: bits self-clear
          ctrl_next  = FSP_CTRL_RST;                          // [RULE_17]
          state_next = FSP_IDLE;
        end else begin
          win_next = win_reg - 3'h1;
        end
      end
      FSP_BUSY: begin
        // cpu held until the flash core reports completion
        if (cif.done) begin
          halt_next  = 1'b0;                                  // [RULE_21]
          ctrl_next  = FSP_CTRL_RST;                          // [RULE_17]
          state_next = FSP_IDLE;
        end
      end
      default: begin
        state_next = FSP_IDLE;
        ctrl_next  = FSP_CTRL_RST;
        halt_next  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      state_reg <= FSP_IDLE;
      ctrl_reg  <= FSP_CTRL_RST;
      win_reg   <= 3'h0;
      halt_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      ctrl_reg  <= ctrl_next;
      win_reg   <= win_next;
      halt_reg  <= halt_next;
    end
  end

  // ----------------------------------------------------------------
  // load instruction: byte addressed, z bit 0 picks the half
  // ----------------------------------------------------------------
  always_comb begin
    lval_next = LOAD_STB;
    byte_next = byte_reg;
    if (LOAD_STB) begin
      byte_next = Z_ADDR[0] ? cif.rd_word[15:8] : cif.rd_word[7:0]; // [RULE_15]
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      lval_reg <= 1'b0;
      byte_reg <= 8'h00;
    end else begin
      lval_reg <= lval_next;
      byte_reg <= byte_next;
    end
  end

  // ----------------------------------------------------------------
  // flash array and page buffer; geometry from parameters
  // ----------------------------------------------------------------
  fsp_flash_core #(
    .WORD_BITS (WORD_BITS),          // [RULE_20]
    .PAGE_BITS (PAGE_BITS),          // [RULE_20]
    .OP_CYCLES (OP_CYCLES)
  ) u_core (
    .REF_CLK (REF_CLK),
    .RST_B   (RST_B),
    .cif     (cif)
  );

  // outputs straight from flops
  assign WB_ACK_O   = ack_reg;
  assign WB_DAT_O   = dat_reg;
  assign CPU_HALT   = halt_reg;
  assign LOAD_BYTE  = byte_reg;
  assign LOAD_VALID = lval_reg;

endmodule // fsp_seq

// [fsp_seq_props.sv]
// concurrent checks on the sequencer's bus, stall and load ports
`timescale 1ns/10ps
module fsp_seq_props
  import fsp_pkg::*;
#(
  parameter int WORD_BITS = 4,
  parameter int PAGE_BITS = 5,
  parameter int OP_CYCLES = 1000
) (
  input wire logic        REF_CLK,
  input wire logic        RST_B,
  input wire logic        WB_CYC_I,
  input wire logic        WB_STB_I,
  input wire logic        WB_WE_I,
  input wire logic [7:0]  WB_ADR_I,
  input wire logic [3:0]  WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic        WB_ACK_O,
  input wire logic        STORE_STB,
  input wire logic        LOAD_STB,
  input wire logic [15:0] Z_ADDR,
  input wire logic [15:0] STORE_DATA,
  input wire logic        EE_WRITE_BUSY,
  input wire logic        SELF_PROG_FUSE_B,
  input wire logic [7:0]  LOAD_BYTE,
  input wire logic        LOAD_VALID,
  input wire logic        CPU_HALT
);
  // ------------------------------
  // stall length counter
  // ------------------------------
  logic [31:0] halt_cnt_reg;   // stalled cycles in a row
  logic [31:0] halt_cnt_next;  // next count
  // counts while stalled; a delay-range check could not follow the parameter
  always_comb begin
    halt_cnt_next = CPU_HALT ? halt_cnt_reg + 32'h1 : 32'h0;
  end
  // register only
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      halt_cnt_reg <= 32'h0;
    end else begin
      halt_cnt_reg <= halt_cnt_next;
    end
  end
  // ------------------------------
  // properties
  // ------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);
  // a request taken, then a single-cycle answer
  sequence s_bus_req;
    WB_CYC_I && WB_STB_I && !WB_ACK_O;
  endsequence
  sequence s_ack_pulse;
    WB_ACK_O ##1 !WB_ACK_O;
  endsequence
  a_ack_one_cycle: assert property (s_bus_req |=> s_ack_pulse)
    else $error("bus ack is not one cycle after the request");
  a_ack_has_req: assert property (WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I))
    else $error("bus ack without a request");
  a_halt_from_store: assert property ($rose(CPU_HALT) |-> $past(STORE_STB) || $past(STORE_STB, 2))
    else $error("stall raised without a store instruction");
  a_halt_needs_fuse: assert property ($rose(CPU_HALT) |-> !$past(SELF_PROG_FUSE_B))
    else $error("stall raised with the fuse blank");
  a_halt_ee_idle: assert property ($rose(CPU_HALT) |-> !$past(EE_WRITE_BUSY))
    else $error("stall raised during an eeprom write");
  a_halt_bounded: assert property (CPU_HALT |-> halt_cnt_reg <= OP_CYCLES + 1)
    else $error("stall held too long");
  a_halt_full_op: assert property ($fell(CPU_HALT) |-> halt_cnt_reg >= OP_CYCLES)
    else $error("stall released before the flash operation ended");
  a_load_answer: assert property (LOAD_STB |=> LOAD_VALID)
    else $error("load instruction got no byte");
  a_load_cause: assert property (LOAD_VALID |-> $past(LOAD_STB))
    else $error("load byte valid without a load instruction");
endmodule  // fsp_seq_props

// [fsp_cpu_model.sv]
// behavioural cpu core issuing store and load program instructions
`timescale 1ns/10ps
module fsp_cpu_model (
  input  wire logic        clk,
  input  wire logic        halt,
  input  wire logic [7:0]  load_byte,
  input  wire logic        load_valid,
  output logic             store_stb,
  output logic             load_stb,
  output logic      [15:0] z_addr,
  output logic      [15:0] store_data
);
  // ------------------------------
  // instruction issue
  // ------------------------------
  initial begin
    store_stb  = 1'b0;
    load_stb   = 1'b0;
    z_addr     = 16'h0000;
    store_data = 16'h0000;
  end
  // a stalled core executes nothing until the stall lifts
  task automatic issue_slot();
    @(posedge clk);
    while (halt === 1'b1) @(posedge clk);
  endtask
  // one store; pointer and data inverted after so nothing stale lingers
  task automatic store(input logic [15:0] z, input logic [15:0] d);
    issue_slot();
    store_stb  <= 1'b1;
    z_addr     <= z;
    store_data <= d;
    @(posedge clk);
    store_stb  <= 1'b0;
    z_addr     <= ~z;
    store_data <= ~d;
  endtask
  // one load; byte taken the cycle after the instruction
  task automatic load(input logic [15:0] z, output logic [7:0] b, output logic v);
    issue_slot();
    load_stb <= 1'b1;
    z_addr   <= z;
    @(posedge clk);
    load_stb <= 1'b0;
    z_addr   <= ~z;
    @(posedge clk);
    b = load_byte;
    v = load_valid;
  endtask
endmodule  // fsp_cpu_model

// [fsp_seq_tb.sv]
// self-checking bench for the flash self-programming sequencer
`timescale 1ns/10ps
module fsp_seq_tb;
  import fsp_pkg::*;
  localparam int OPC = 8;  // short flash timer keeps the run brief
  logic        REF_CLK, RST_B, WB_CYC_I, WB_STB_I, WB_WE_I, EE_WRITE_BUSY, SELF_PROG_FUSE_B;
  logic        WB_ACK_O, STORE_STB, LOAD_STB, LOAD_VALID, CPU_HALT, v;
  logic [7:0]  WB_ADR_I, LOAD_BYTE, b;
  logic [3:0]  WB_SEL_I;
  logic [31:0] WB_DAT_I, WB_DAT_O, q;
  logic [15:0] Z_ADDR, STORE_DATA, exp_pg [16];
  logic [4:0]  bad [5] = '{5'h02, 5'h07, 5'h09, 5'h15, 5'h1F};
  logic [3:0]  wl [3] = '{4'h5, 4'h0, 4'hF};
  int          n_errors = 0, num_checks = 0, n;

  initial begin
    REF_CLK = 1'b0;
    forever #5 REF_CLK = ~REF_CLK;
  end
  fsp_seq #(.OP_CYCLES(OPC)) fsp_seq_i (.REF_CLK(REF_CLK), .RST_B(RST_B), .WB_CYC_I(WB_CYC_I),
    .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I),
    .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .STORE_STB(STORE_STB),
    .LOAD_STB(LOAD_STB), .Z_ADDR(Z_ADDR), .STORE_DATA(STORE_DATA), .EE_WRITE_BUSY(EE_WRITE_BUSY),
    .SELF_PROG_FUSE_B(SELF_PROG_FUSE_B), .LOAD_BYTE(LOAD_BYTE), .LOAD_VALID(LOAD_VALID),
    .CPU_HALT(CPU_HALT));
  fsp_cpu_model fsp_cpu_model_i (.clk(REF_CLK), .halt(CPU_HALT), .load_byte(LOAD_BYTE),
    .load_valid(LOAD_VALID), .store_stb(STORE_STB), .load_stb(LOAD_STB), .z_addr(Z_ADDR),
    .store_data(STORE_DATA));
  // ------------------------------
  // access tasks
  // ------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // classic single wishbone cycle, held until ack is sampled
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge REF_CLK);
    WB_CYC_I <= 1'b1;
    WB_STB_I <= 1'b1;
    WB_WE_I  <= we;
    WB_ADR_I <= a;
    WB_SEL_I <= 4'hF;
    WB_DAT_I <= d;
    // no cycle count assumed; only the watchdog ends a hung wait
    do begin
      @(posedge REF_CLK);
    end while (WB_ACK_O !== 1'b1);
    q = WB_DAT_O;
    WB_CYC_I <= 1'b0;
    WB_STB_I <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    wb(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask
  // arm a command, then store within the four-cycle window
  task automatic op(input logic [4:0] c, input logic [15:0] z, input logic [15:0] d);
    wb(1'b1, FSP_CTRL_ADDR, {27'h0, c});
    fsp_cpu_model_i.store(z, d);
  endtask
  function automatic logic [15:0] zp(input logic [4:0] p, input logic [3:0] w, input logic bt);
    return {6'h00, p, w, bt};
  endfunction
  // stall must show, then lift within a bounded wait
  task automatic wait_idle();
    repeat (2) @(posedge REF_CLK);
    chk("halt raised", 32'h1, {31'h0, CPU_HALT});
    n = 0;
    while (CPU_HALT !== 1'b0 && n < 100) begin
      @(posedge REF_CLK);
      n++;
    end
    chk("halt released", 32'h0, {31'h0, CPU_HALT});
  endtask
  // every byte of a page through load instructions
  task automatic check_page(input logic [4:0] p);
    for (int w = 0; w < 16; w++) begin
      for (int bt = 0; bt < 2; bt++) begin
        fsp_cpu_model_i.load(zp(p, w[3:0], bt[0]), b, v);
        chk("load byte", {24'h0, bt[0] ? exp_pg[w][15:8] : exp_pg[w][7:0]}, {24'h0, b});
        chk("load valid", 32'h1, {31'h0, v});
      end
    end
  endtask
  task automatic end_of_test();
    if (n_errors == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ------------------------------
  // tests
  // ------------------------------
  initial begin
    RST_B = 1'b0;
    {WB_CYC_I, WB_STB_I, WB_WE_I, EE_WRITE_BUSY, SELF_PROG_FUSE_B} = 5'h00;
    WB_ADR_I = 8'h00;
    WB_SEL_I = 4'hF;
    WB_DAT_I = 32'h0;
    repeat (2) @(posedge REF_CLK);
    RST_B <= 1'b1;
    rd(FSP_STAT_ADDR, 32'h2, "status after reset");
    wb(1'b1, 8'h08, 32'h1F);
    rd(8'h08, 32'h0, "unmapped");
    foreach (bad[i]) begin
      wb(1'b1, FSP_CTRL_ADDR, {27'h0, bad[i]});
      rd(FSP_CTRL_ADDR, 32'h0, "ctrl after bad code");
    end
    foreach (exp_pg[i]) exp_pg[i] = FSP_ERASED;
    exp_pg[5] = 16'h1357;
    exp_pg[0] = 16'hA5C3;
    exp_pg[15] = 16'h0F0F;
    // fill out of order before erase, each word once, Z bit0 ignored
    foreach (wl[i]) op(FSP_CMD_LOAD, zp(5'h03, wl[i], 1'b1), exp_pg[wl[i]]);
    rd(FSP_STAT_ADDR, 32'hA, "status loaded");
    op(FSP_CMD_ERASE, zp(5'h03, 4'h9, 1'b1), 16'h1234);
    rd(FSP_CTRL_ADDR, {27'h0, FSP_CMD_ERASE}, "ctrl in erase");
    wait_idle();
    rd(FSP_STAT_ADDR, 32'hA, "status kept over erase");
    op(FSP_CMD_WRITE, zp(5'h03, 4'h0, 1'b0), 16'hDEAD);
    rd(FSP_CTRL_ADDR, {27'h0, FSP_CMD_WRITE}, "ctrl in write");
    wait_idle();
    rd(FSP_STAT_ADDR, 32'h2, "status after write");
    check_page(5'h03);
    // erase first, then fill, then write
    foreach (exp_pg[i]) exp_pg[i] = FSP_ERASED;
    exp_pg[2] = 16'h5AC3;
    op(FSP_CMD_ERASE, zp(5'h04, 4'h0, 1'b0), 16'h0000);
    wait_idle();
    op(FSP_CMD_LOAD, zp(5'h04, 4'h2, 1'b0), exp_pg[2]);
    op(FSP_CMD_WRITE, zp(5'h04, 4'h0, 1'b0), 16'h0000);
    wait_idle();
    check_page(5'h04);
    op(FSP_CMD_LOAD, zp(5'h01, 4'h3, 1'b0), 16'h2222);
    wb(1'b1, FSP_CTRL_ADDR, {27'h0, FSP_CMD_CLEAR});
    rd(FSP_STAT_ADDR, 32'h2, "status after clear");
    // store arriving after the window closes
    wb(1'b1, FSP_CTRL_ADDR, {27'h0, FSP_CMD_ERASE});
    repeat (5) @(posedge REF_CLK);
    fsp_cpu_model_i.store(zp(5'h01, 4'h0, 1'b0), 16'h0000);
    repeat (2) @(posedge REF_CLK);
    chk("halt after late store", 32'h0, {31'h0, CPU_HALT});
    rd(FSP_CTRL_ADDR, 32'h0, "ctrl after expiry");
    op(FSP_CMD_LOAD, zp(5'h01, 4'h1, 1'b0), 16'h3333);
    EE_WRITE_BUSY <= 1'b1;
    rd(FSP_STAT_ADDR, 32'h6, "status in eeprom write");
    wb(1'b1, FSP_CTRL_ADDR, {27'h0, FSP_CMD_WRITE});
    rd(FSP_CTRL_ADDR, 32'h0, "ctrl in eeprom write");
    EE_WRITE_BUSY <= 1'b0;
    SELF_PROG_FUSE_B <= 1'b1;
    op(FSP_CMD_LOAD, zp(5'h01, 4'h1, 1'b0), 16'h4444);
    rd(FSP_STAT_ADDR, 32'h0, "status fuse blank");
    SELF_PROG_FUSE_B <= 1'b0;
    // cleared, discarded and refused loads must leave nothing to program
    foreach (exp_pg[i]) exp_pg[i] = FSP_ERASED;
    op(FSP_CMD_ERASE, zp(5'h01, 4'h0, 1'b0), 16'h0000);
    wait_idle();
    op(FSP_CMD_WRITE, zp(5'h01, 4'h0, 1'b0), 16'h0000);
    wait_idle();
    check_page(5'h01);
    op(FSP_CMD_LOAD, zp(5'h01, 4'h1, 1'b0), 16'h5555);
    RST_B <= 1'b0;
    repeat (2) @(posedge REF_CLK);
    RST_B <= 1'b1;
    rd(FSP_STAT_ADDR, 32'h2, "status after reset");
    end_of_test();
  end
  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge REF_CLK);
    n_errors++;
    end_of_test();
  end
endmodule  // fsp_seq_tb

bind fsp_seq fsp_seq_props #(.WORD_BITS(WORD_BITS), .PAGE_BITS(PAGE_BITS), .OP_CYCLES(OP_CYCLES))
  fsp_seq_props_i (.REF_CLK(REF_CLK), .RST_B(RST_B), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
  .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
  .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .STORE_STB(STORE_STB), .LOAD_STB(LOAD_STB),
  .Z_ADDR(Z_ADDR), .STORE_DATA(STORE_DATA), .EE_WRITE_BUSY(EE_WRITE_BUSY),
  .SELF_PROG_FUSE_B(SELF_PROG_FUSE_B), .LOAD_BYTE(LOAD_BYTE), .LOAD_VALID(LOAD_VALID),
  .CPU_HALT(CPU_HALT));
